// [design/qpc_top.sv]
// Quadrature position counter with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module qpc_top
    import qpc_pkg::*;
#(
    parameter int VEL_W = 16
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        phase_a_input,
    input  wire logic        phase_b_input,
    input  wire logic        index_input,
    input  wire logic        home_input,
    input  wire logic        ext_clk_input,
    input  wire logic        ext_updown_input,
    input  wire logic        ext_gate_input,
    input  wire logic        cpu_idle
);
    qpc_con_type          con_reg;
    qpc_io_type           io_reg;
    logic [31:0]          pos_reg;
    logic [31:0]          pos_next;
    logic [31:0]          idx_cnt_reg;
    logic [31:0]          tmr_reg;
    logic [VEL_W-1:0]     vel_reg;
    logic [31:0]          init_value_reg;
    logic [31:0]          low_compare_reg;
    logic [7:0]           adr_reg;
    logic                 wr_pend_reg;
    logic                 rd_pend_reg;
    logic [31:0]          hrdata_reg;
    logic                 hreadyout_reg;
    logic                 hresp_reg;
    logic [31:0]          rd_mux;
    logic [QPC_PIN_N-1:0] pin_raw;
    logic [QPC_PIN_N-1:0] s1_reg;
    logic [QPC_PIN_N-1:0] s2_reg;
    logic [QPC_PIN_N-1:0] s3_reg;
    logic [QPC_PIN_N-1:0] pin_f_reg;
    logic [7:0]           div_reg;
    logic                 qa_prev_reg;
    logic                 qb_prev_reg;
    logic                 idx_prev_reg;
    logic                 home_prev_reg;
    logic                 xclk_prev_reg;
    logic                 next_arm_reg;
    logic                 home_arm_reg;
    logic                 home_idx_reg;
    logic                 last_up_reg;
    logic                 src;
    logic                 step_up;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Bus decode
    wire accept = hsel && htrans[1] && hready;
    wire wr_con = wr_pend_reg && (adr_reg == QPC_OFF_CON);
    wire wr_ioc = wr_pend_reg && (adr_reg == QPC_OFF_IOC);
    wire wr_pos = wr_pend_reg && (adr_reg == QPC_OFF_POS);
    wire wr_idx = wr_pend_reg && (adr_reg == QPC_OFF_IDX);
    wire wr_tmr = wr_pend_reg && (adr_reg == QPC_OFF_TMR);
    wire wr_vel = wr_pend_reg && (adr_reg == QPC_OFF_VEL);
    wire wr_ini = wr_pend_reg && (adr_reg == QPC_OFF_INIT);
    wire wr_low = wr_pend_reg && (adr_reg == QPC_OFF_LOW);

    // Synchronised and conditioned pins
    assign pin_raw = {ext_gate_input, ext_updown_input, ext_clk_input,
                      home_input, index_input, phase_b_input, phase_a_input};

    genvar gi;
    generate
        for (gi = 0; gi < QPC_PIN_N; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_reg[gi]    <= 1'b0;
                    s2_reg[gi]    <= 1'b0;
                    s3_reg[gi]    <= 1'b0;
                    pin_f_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= pin_raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        pin_f_reg[gi] <= s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    wire a_c    = pin_f_reg[QPC_PIN_A] ^ io_reg.phase_a_invert;
    wire b_c    = pin_f_reg[QPC_PIN_B] ^ io_reg.phase_b_invert;
    wire idx_c  = pin_f_reg[QPC_PIN_IDX] ^ io_reg.index_invert;
    wire home_c = pin_f_reg[QPC_PIN_HOME] ^ io_reg.home_invert;
    wire a_sw   = io_reg.phase_swap ? b_c : a_c;
    wire b_sw   = io_reg.phase_swap ? a_c : b_c;

    // Run control and prescaler
    wire       run  = con_reg.counters_on && !(con_reg.halt_in_idle && cpu_idle);
    wire [7:0] mask = QPC_DIV_MASK[con_reg.timer_clock_divider];
    wire       tick = run && (div_reg == mask);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 8'h00;
        end else if (!run || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // Count source selection
    wire quad_step = tick && ((a_sw ^ qa_prev_reg) ^ (b_sw ^ qb_prev_reg));
    wire quad_up   = a_sw ^ qb_prev_reg;
    wire xclk_rise = tick && pin_f_reg[QPC_PIN_XCLK] && !xclk_prev_reg;
    wire pol_up    = !con_reg.count_direction_sel;

    always_comb begin
        src     = 1'b0;
        step_up = pol_up;
        case (con_reg.counter_source_mode)
            QPC_CCM_QUAD: begin
                src     = quad_step;
                step_up = quad_up ^ con_reg.count_direction_sel;
            end
            QPC_CCM_UPDN: begin
                src     = xclk_rise;
                step_up = pin_f_reg[QPC_PIN_UPDN];
            end
            QPC_CCM_EXT: begin
                src = xclk_rise;
            end
            QPC_CCM_TMR: begin
                src = tick;
            end
            default: begin
                src = 1'b0;
            end
        endcase
    end

    wire adv = src && (!con_reg.gate_control_on || pin_f_reg[QPC_PIN_GATE]);

    // Index and home qualification
    wire       timer_mode = con_reg.counter_source_mode[1];
    wire [2:0] pim        = con_reg.pos_init_policy;
    wire [1:0] imv        = con_reg.index_phase_match;
    wire       idx_rise   = tick && idx_c && !idx_prev_reg;
    wire       home_rise  = tick && home_c && !home_prev_reg;
    wire       phase_hit  = ({b_sw, a_sw} == imv);
    wire       idx_evt    = idx_rise && ((imv == 2'h0) || phase_hit);
    wire       idx_pos    = idx_rise && (imv != 2'h0) && phase_hit && !timer_mode;
    wire       ld_init    = idx_pos && (((pim == QPC_PIM_NEXT) && next_arm_reg)
                          || ((pim == QPC_PIM_HOME1) && home_arm_reg && !home_idx_reg)
                          || ((pim == QPC_PIM_HOME2) && home_arm_reg && home_idx_reg));
    wire       clr_idx    = idx_pos && (pim == QPC_PIM_RST)
                          && (con_reg.counter_source_mode == QPC_CCM_QUAD);
    wire       clr_geq    = tick && !timer_mode && (pim == QPC_PIM_GEQ) && (pos_reg == init_value_reg);
    wire       mod_wrap   = adv && !timer_mode && (pim == QPC_PIM_MOD)
                          && (step_up ? (pos_reg == init_value_reg) : (pos_reg == low_compare_reg));
    wire       idx_up     = adv ? step_up : last_up_reg;

    always_comb begin
        pos_next = pos_reg;
        if (wr_pos) begin
            pos_next = hwdata;
        end else if (clr_idx || clr_geq) begin
            pos_next = QPC_CNT_RST;
        end else if (ld_init) begin
            pos_next = init_value_reg;
        end else if (mod_wrap) begin
            pos_next = step_up ? low_compare_reg : init_value_reg;
        end else if (adv) begin
            pos_next = step_up ? pos_reg + 32'h1 : pos_reg - 32'h1;
        end
    end

    // Edge history follows the pins while stopped so that restart counts nothing stale
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qa_prev_reg   <= 1'b0;
            qb_prev_reg   <= 1'b0;
            idx_prev_reg  <= 1'b0;
            home_prev_reg <= 1'b0;
            xclk_prev_reg <= 1'b0;
        end else if (tick || !run) begin
            qa_prev_reg   <= a_sw;
            qb_prev_reg   <= b_sw;
            idx_prev_reg  <= idx_c;
            home_prev_reg <= home_c;
            xclk_prev_reg <= pin_f_reg[QPC_PIN_XCLK];
        end
    end

    // Homing sequence state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            next_arm_reg <= 1'b0;
            home_arm_reg <= 1'b0;
            home_idx_reg <= 1'b0;
        end else begin
            if (wr_con) begin
                next_arm_reg <= 1'b1;
            end else if (ld_init) begin
                next_arm_reg <= 1'b0;
            end
            if (home_rise) begin
                home_arm_reg <= 1'b1;
                home_idx_reg <= 1'b0;
            end else if (ld_init) begin
                home_arm_reg <= 1'b0;
            end else if (idx_pos && home_arm_reg) begin
                home_idx_reg <= 1'b1;
            end
        end
    end

    // Counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_reg     <= QPC_CNT_RST;
            idx_cnt_reg <= QPC_CNT_RST;
            tmr_reg     <= QPC_CNT_RST;
            vel_reg     <= '0;
            last_up_reg <= 1'b1;
        end else begin
            pos_reg <= pos_next;
            if (adv) begin
                last_up_reg <= step_up;
            end
            if (wr_idx) begin
                idx_cnt_reg <= hwdata;
            end else if (idx_evt) begin
                idx_cnt_reg <= idx_up ? idx_cnt_reg + 32'h1 : idx_cnt_reg - 32'h1;
            end
            if (wr_tmr) begin
                tmr_reg <= hwdata;
            end else if (tick) begin
                tmr_reg <= tmr_reg + 32'h1;
            end
            if (wr_vel) begin
                vel_reg <= hwdata[VEL_W-1:0];
            end else if (adv) begin
                vel_reg <= step_up ? vel_reg + 1'b1 : vel_reg - 1'b1;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            con_reg         <= QPC_CON_RST;
            io_reg          <= QPC_IOC_RST;
            init_value_reg  <= QPC_CNT_RST;
            low_compare_reg <= QPC_CNT_RST;
        end else begin
            if (wr_con) begin
                con_reg <= hwdata[15:0] & QPC_CON_WMASK;
            end
            if (wr_ioc) begin
                io_reg <= hwdata[15:0] & QPC_IOC_WMASK;
            end
            if (wr_ini) begin
                init_value_reg <= hwdata;
            end
            if (wr_low) begin
                low_compare_reg <= hwdata;
            end
        end
    end

    // Read selection
    always_comb begin
        case (adr_reg)
            QPC_OFF_CON:  rd_mux = {16'h0000, con_reg};
            QPC_OFF_IOC:  rd_mux = {16'h0000, io_reg[15:4], home_c, idx_c, b_sw, a_sw};
            QPC_OFF_POS:  rd_mux = pos_reg;
            QPC_OFF_IDX:  rd_mux = idx_cnt_reg;
            QPC_OFF_TMR:  rd_mux = tmr_reg;
            QPC_OFF_VEL:  rd_mux = {{(32-VEL_W){1'b0}}, vel_reg};
            QPC_OFF_INIT: rd_mux = init_value_reg;
            QPC_OFF_LOW:  rd_mux = low_compare_reg;
            QPC_OFF_STAT: rd_mux = {28'h0000000, home_arm_reg, home_idx_reg, next_arm_reg, run};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // AHB-Lite slave: writes finish without wait, reads take one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adr_reg       <= 8'h00;
            wr_pend_reg   <= 1'b0;
            rd_pend_reg   <= 1'b0;
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hresp_reg   <= 1'b0;
            wr_pend_reg <= accept && hwrite;
            rd_pend_reg <= accept && !hwrite;
            if (accept) begin
                adr_reg <= {haddr[7:2], 2'b00};
            end
            if (accept && !hwrite) begin
                hreadyout_reg <= 1'b0;
            end else if (rd_pend_reg) begin
                hrdata_reg    <= rd_mux;
                hreadyout_reg <= 1'b1;
            end
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;

    AST_STOPPED: assert property (!con_reg.counters_on && !wr_pos |=> pos_reg == $past(pos_reg))
        else $error("position moved while counters disabled");
    AST_IDLE_HALT: assert property (con_reg.halt_in_idle && cpu_idle |-> !tick)
        else $error("prescaler ticked in idle with halt set");
    AST_IDX_RESET: assert property (
        idx_pos && (pim == QPC_PIM_RST) && (con_reg.counter_source_mode == QPC_CCM_QUAD) && !wr_pos
        |=> pos_reg == 32'h0)
        else $error("index did not clear position");
    AST_NEXT_LOAD: assert property (
        idx_pos && (pim == QPC_PIM_NEXT) && next_arm_reg && !wr_pos && !wr_con
        |=> (pos_reg == $past(init_value_reg)) && !next_arm_reg)
        else $error("next index load failed");
    AST_HOME2_LOAD: assert property (
        idx_pos && (pim == QPC_PIM_HOME2) && home_arm_reg && home_idx_reg && !wr_pos && !home_rise
        |=> (pos_reg == $past(init_value_reg)) && !home_arm_reg)
        else $error("second index after home did not load");
    AST_GEQ_RESET: assert property (clr_geq && !wr_pos |=> pos_reg == 32'h0)
        else $error("compare reset missing");
    AST_MOD_WRAP: assert property (
        mod_wrap && step_up && !wr_pos && !clr_idx && !ld_init
        |=> pos_reg == $past(low_compare_reg))
        else $error("modulo wrap wrong");
    AST_DIV_256: assert property (tick && (con_reg.timer_clock_divider == 3'h7) |=> !tick [*8])
        else $error("prescale 256 ticked early");
    AST_GATE: assert property (con_reg.gate_control_on && !pin_f_reg[QPC_PIN_GATE] |-> !adv)
        else $error("count advanced with gate closed");
    AST_TIMER_DIR: assert property (
        adv && (con_reg.counter_source_mode == QPC_CCM_TMR) && !wr_pos
        |=> pos_reg == ($past(con_reg.count_direction_sel) ? $past(pos_reg) - 32'h1
                                                           : $past(pos_reg) + 32'h1))
        else $error("timer direction wrong");
    AST_TIMER_MODE: assert property (timer_mode |-> !ld_init && !clr_geq && !clr_idx)
        else $error("init policy acted in timer mode");
endmodule
`default_nettype wire

// [pkg/qpc_pkg.sv]
// Constants and types of the quadrature position counter block
package qpc_pkg;
    localparam logic [7:0]  QPC_OFF_CON  = 8'h00;
    localparam logic [7:0]  QPC_OFF_IOC  = 8'h04;
    localparam logic [7:0]  QPC_OFF_POS  = 8'h08;
    localparam logic [7:0]  QPC_OFF_IDX  = 8'h0c;
    localparam logic [7:0]  QPC_OFF_TMR  = 8'h10;
    localparam logic [7:0]  QPC_OFF_VEL  = 8'h14;
    localparam logic [7:0]  QPC_OFF_INIT = 8'h18;
    localparam logic [7:0]  QPC_OFF_LOW  = 8'h1c;
    localparam logic [7:0]  QPC_OFF_STAT = 8'h20;
    localparam logic [15:0] QPC_CON_WMASK = 16'hbf7f;
    localparam logic [15:0] QPC_IOC_WMASK = 16'h01f0;
    localparam logic [15:0] QPC_CON_RST = 16'h0000;
    localparam logic [15:0] QPC_IOC_RST = 16'h0000;
    localparam logic [31:0] QPC_CNT_RST = 32'h0000_0000;
    localparam logic [2:0]  QPC_PIM_RST   = 3'h1;
    localparam logic [2:0]  QPC_PIM_NEXT  = 3'h2;
    localparam logic [2:0]  QPC_PIM_HOME1 = 3'h3;
    localparam logic [2:0]  QPC_PIM_HOME2 = 3'h4;
    localparam logic [2:0]  QPC_PIM_GEQ   = 3'h5;
    localparam logic [2:0]  QPC_PIM_MOD   = 3'h6;
    localparam logic [1:0]  QPC_CCM_QUAD = 2'h0;
    localparam logic [1:0]  QPC_CCM_UPDN = 2'h1;
    localparam logic [1:0]  QPC_CCM_EXT  = 2'h2;
    localparam logic [1:0]  QPC_CCM_TMR  = 2'h3;
    localparam logic [7:0]  QPC_DIV_MASK [8] = '{8'h00, 8'h01, 8'h03, 8'h07,
                                                 8'h0f, 8'h1f, 8'h3f, 8'hff};
    localparam int          QPC_PIN_A    = 0;
    localparam int          QPC_PIN_B    = 1;
    localparam int          QPC_PIN_IDX  = 2;
    localparam int          QPC_PIN_HOME = 3;
    localparam int          QPC_PIN_XCLK = 4;
    localparam int          QPC_PIN_UPDN = 5;
    localparam int          QPC_PIN_GATE = 6;
    localparam int          QPC_PIN_N    = 7;

    typedef struct packed {
        logic       counters_on;
        logic       rsv14;
        logic       halt_in_idle;
        logic [2:0] pos_init_policy;
        logic [1:0] index_phase_match;
        logic       rsv7;
        logic [2:0] timer_clock_divider;
        logic       count_direction_sel;
        logic       gate_control_on;
        logic [1:0] counter_source_mode;
    } qpc_con_type;

    typedef struct packed {
        logic [6:0] rsv_hi;
        logic       phase_swap;
        logic       home_invert;
        logic       index_invert;
        logic       phase_b_invert;
        logic       phase_a_invert;
        logic [3:0] rsv_lo;
    } qpc_io_type;
endpackage

// [test/qpc_encoder_model.sv]
// Behavioural incremental encoder with phases, index and home
`timescale 1ns/10ps
`default_nettype none
module qpc_encoder_model (
    input  wire logic clk,
    output var  logic pha,
    output var  logic phb,
    output var  logic idx,
    output var  logic home
);
    localparam int GAP = 12;
    logic [1:0] st = 2'h0;

    initial begin
        pha = 1'b0;
        phb = 1'b0;
        idx = 1'b0;
        home = 1'b0;
    end

    // Gray step, A leads B going forward; spacing far above the prescaled rate
    task automatic step(input logic fwd);
        @(posedge clk);
        st = fwd ? st + 2'h1 : st - 2'h1;
        pha <= st[1] ^ st[0];
        phb <= st[1];
        repeat (GAP) @(posedge clk);
    endtask

    // Index or home pulse, phases held still meanwhile
    task automatic pulse(input logic hm);
        @(posedge clk);
        if (hm) home <= 1'b1;
        else idx <= 1'b1;
        repeat (GAP) @(posedge clk);
        home <= 1'b0;
        idx <= 1'b0;
        repeat (GAP) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [test/qpc_top_tb.sv]
// Self-checking bench for the quadrature position counter block
`timescale 1ns/10ps
`default_nettype none
module qpc_top_tb
    import qpc_pkg::*;
;
    localparam int LIMIT = 60000;
    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        xclk = 1'b0;
    logic        updn = 1'b1;
    logic        gate = 1'b1;
    logic        idle = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pha;
    logic        phb;
    logic        idx;
    logic        home;
    logic [31:0] q;
    logic [31:0] t0;
    logic [15:0] rnd = 16'h0029;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    logic [15:0] qcon [7] = '{16'h8000, 16'h8008, 16'h0000, 16'ha000, 16'h8000, 16'h8004, 16'h8004};
    logic        qidl [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic        qgat [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    int          qsgn [7] = '{1, -1, 0, 0, 1, 0, 1};

    always #10 hclk = ~hclk;

    qpc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .phase_a_input(pha), .phase_b_input(phb),
        .index_input(idx), .home_input(home), .ext_clk_input(xclk), .ext_updown_input(updn),
        .ext_gate_input(gate), .cpu_idle(idle));
    qpc_encoder_model u_enc (.clk(hclk), .pha(pha), .phb(phb), .idx(idx), .home(home));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] ticks(input logic [31:0] c, input logic [2:0] d);
        return c >> ((d == 3'h7) ? 8 : d);
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h range %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic settle();
        repeat (12) @(posedge hclk);
    endtask
    task automatic quad_run(input logic [15:0] con, input int k, input logic [31:0] exp);
        wr(QPC_OFF_CON, {16'h0, con});
        settle();
        wr(QPC_OFF_POS, 32'h0);
        wr(QPC_OFF_VEL, 32'h0);
        repeat (k) u_enc.step(1'b1);
        settle();
        rd(QPC_OFF_POS, exp);
    endtask
    task automatic idx_case(input logic [2:0] pol, input logic [1:0] imv, input logic hm, input int k,
                            input logic [31:0] exp, input logic [31:0] di);
        wr(QPC_OFF_INIT, 32'h100);
        wr(QPC_OFF_CON, {16'h0, 3'b100, pol, imv, 8'h00});
        while (u_enc.st != 2'h1) u_enc.step(1'b1);
        settle();
        wr(QPC_OFF_POS, 32'h55);
        bus(1'b0, QPC_OFF_IDX, 32'h0, t0);
        if (hm) u_enc.pulse(1'b1);
        repeat (k) u_enc.pulse(1'b0);
        settle();
        rd(QPC_OFF_POS, exp);
        rd(QPC_OFF_IDX, t0 + di);
    endtask
    task automatic xpulses(input int k);
        repeat (k) begin
            xclk <= 1'b1;
            repeat (8) @(posedge hclk);
            xclk <= 1'b0;
            repeat (8) @(posedge hclk);
        end
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        // Unknown to low gives the asynchronous reset a real falling edge
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(QPC_OFF_CON, 32'h0);
        rd(QPC_OFF_POS, 32'h0);
        wr(QPC_OFF_CON, 32'hffff_ffff);
        rd(QPC_OFF_CON, 32'h0000_bf7f);
        wr(QPC_OFF_CON, 32'h0);
        wr(8'h24, {rnd, ~rnd});
        rd(8'h24, 32'h0);
        wr(QPC_OFF_POS, {~rnd, rnd});
        settle();
        rd(QPC_OFF_POS, {~rnd, rnd});
        rnd = lfsr(rnd);
        wr(QPC_OFF_INIT, {rnd, ~rnd});
        rd(QPC_OFF_INIT, {rnd, ~rnd});
        wr(QPC_OFF_LOW, {~rnd, rnd});
        rd(QPC_OFF_LOW, {~rnd, rnd});
        for (int i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            n = 1 + int'(rnd[2:0]);
            idle <= qidl[i];
            gate <= qgat[i];
            quad_run(qcon[i], n, 32'(qsgn[i] * n));
            rd(QPC_OFF_VEL, {16'h0, 16'(qsgn[i] * n)});
        end
        wr(QPC_OFF_IOC, 32'h100);
        settle();
        rd(QPC_OFF_IOC, {23'h0, 1'b1, 6'h0, u_enc.st[1] ^ u_enc.st[0], u_enc.st[1]});
        quad_run(16'h8000, 3, -32'sd3);
        wr(QPC_OFF_IOC, 32'h0f0);
        settle();
        rd(QPC_OFF_IOC, {24'h0, 4'hf, 2'b11, ~u_enc.st[1], ~(u_enc.st[1] ^ u_enc.st[0])});
        wr(QPC_OFF_IOC, 32'h010);
        quad_run(16'h8000, 5, -32'sd5);
        wr(QPC_OFF_IOC, 32'h0);
        quad_run(16'h8000, 2, 32'h2);
        idx_case(3'h0, 2'h1, 1'b0, 1, 32'h55, 32'h1);
        idx_case(3'h1, 2'h1, 1'b0, 1, 32'h0, 32'h1);
        idx_case(3'h1, 2'h0, 1'b0, 1, 32'h55, 32'h1);
        idx_case(3'h1, 2'h2, 1'b0, 1, 32'h55, 32'h0);
        idx_case(3'h1, 2'h3, 1'b0, 1, 32'h55, 32'h0);
        idx_case(3'h2, 2'h1, 1'b0, 2, 32'h100, 32'h2);
        idx_case(3'h3, 2'h1, 1'b1, 1, 32'h100, 32'h1);
        idx_case(3'h4, 2'h1, 1'b1, 2, 32'h100, 32'h2);
        idx_case(3'h4, 2'h1, 1'b1, 1, 32'h55, 32'h1);
        wr(QPC_OFF_INIT, 32'h3);
        wr(QPC_OFF_LOW, 32'h0);
        quad_run(16'h9400, 5, 32'h2);
        quad_run(16'h9800, 5, 32'h1);
        quad_run(16'h9808, 2, 32'h2);
        rnd = lfsr(rnd);
        n = 1 + int'(rnd[2:0]);
        wr(QPC_OFF_CON, 32'h8001);
        settle();
        wr(QPC_OFF_POS, 32'h0);
        xpulses(n + 2);
        updn <= 1'b0;
        settle();
        xpulses(n);
        settle();
        rd(QPC_OFF_POS, 32'h2);
        wr(QPC_OFF_CON, 32'h800a);
        settle();
        wr(QPC_OFF_POS, 32'h0);
        xpulses(n);
        settle();
        rd(QPC_OFF_POS, 32'(-n));
        for (int c = 0; c < 8; c++) begin
            wr(QPC_OFF_CON, {16'h0, 8'h80, 1'b0, 3'(c), 4'h3});
            bus(1'b0, QPC_OFF_TMR, 32'h0, t0);
            repeat (2048) @(posedge hclk);
            bus(1'b0, QPC_OFF_TMR, 32'h0, q);
            chk_rng(q - t0, ticks(32'd2052, 3'(c)) - 3, ticks(32'd2052, 3'(c)) + 3);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
